// ---- can_acceptance_filter.sv ----
// Design decision made here: the Avalon-MM register port.
`timescale 1ns/1ps

module can_acceptance_filter
  import can_accept_pkg::*;
(
  // Clock and reset
  input  wire logic              sys_clk_i,
  input  wire logic              rstn_i,
  // Avalon-MM slave
  input  wire logic [ADDR_W-1:0] avs_address_i,
  input  wire logic              avs_read_i,
  input  wire logic              avs_write_i,
  input  wire logic [DATA_W-1:0] avs_writedata_i,
  input  wire logic [3:0]        avs_byteenable_i,
  output logic      [DATA_W-1:0] avs_readdata_o,
  output logic                   avs_waitrequest_o,
  // Message assembly buffer
  input  wire logic              mab_valid_i,
  input  wire logic [10:0]       mab_sid_i,
  input  wire logic [17:0]       mab_eid_i,
  input  wire logic              mab_ide_i,
  input  wire logic              mab_rtr_i,
  input  wire logic [3:0]        mab_dlc_i,
  input  wire logic [63:0]       mab_data_i,
  // Buffer-full flags from the buffer logic
  input  wire logic              rx0_full_i,
  input  wire logic              rx1_full_i,
  // Store strobes and mode
  output logic                   rx0_load_o,
  output logic                   rx1_load_o,
  output logic                   config_mode_o
);

  // ---------------------------------------------------------------------------
  // State
  // ---------------------------------------------------------------------------
  logic [31:0]         filt      [0:NUM_FILT-1];
  logic [31:0]         mask      [0:NUM_MASK-1];
  logic [REG_W-1:0]    buf_mem   [0:NUM_BUF-1][0:BUF_BYTES-1];
  logic                config_mode;
  logic                rollover_enable;
  logic                filter_hit_bit0;
  logic [FILTER_HIT_CODE_W-1:0] filter_hit_code1;
  logic                waitreq;
  logic [DATA_W-1:0]   readdata;
  logic                rx0_load;
  logic                rx1_load;

  // ---------------------------------------------------------------------------
  // Bus decode
  // ---------------------------------------------------------------------------
  logic [IDX_W-1:0]    reg_idx;
  logic                req;
  logic                rd_take;
  logic                wr_take;
  logic [4:0]          lane_shift;
  logic [31:0]         lane_mask;
  logic [31:0]         lane_data;
  logic [IDX_W-1:0]    off0;
  logic [IDX_W-1:0]    off1;
  logic                buf0_sel;
  logic                buf1_sel;
  logic                next_waitreq;
  logic [REG_W-1:0]    rd_byte;

  // Word index from byte address; only lane 0 carries register data
  assign reg_idx      = avs_address_i[ADDR_W-1:2];
  assign req          = avs_read_i || avs_write_i;
  assign rd_take      = avs_read_i && waitreq;
  assign wr_take      = avs_write_i && !waitreq && avs_byteenable_i[0];
  // Packed word keeps the high identifier byte at the lowest index
  assign lane_shift   = {~reg_idx[1:0], 3'b000};
  assign lane_mask    = LANE_BYTE << lane_shift;
  assign lane_data    = {24'h00_0000, avs_writedata_i[REG_W-1:0]} << lane_shift;
  assign off0         = reg_idx - RX0_CTRL;
  assign off1         = reg_idx - RX1_CTRL;
  assign buf0_sel     = (reg_idx > RX0_CTRL) && (off0 <= BUF_SPAN);
  assign buf1_sel     = (reg_idx > RX1_CTRL) && (off1 <= BUF_SPAN);
  // One wait cycle per access; waitrequest rises again right after each acceptance
  assign next_waitreq = !(req && waitreq);

  // ---------------------------------------------------------------------------
  // Filter and mask selects
  // ---------------------------------------------------------------------------
  logic [NUM_FILT-1:0] filt_sel;
  logic [NUM_MASK-1:0] mask_sel;
  logic                mode_sel;
  logic                ctrl0_sel;
  logic                ctrl1_sel;

  assign mode_sel  = (reg_idx == MODE_CTRL);
  assign ctrl0_sel = (reg_idx == RX0_CTRL);
  assign ctrl1_sel = (reg_idx == RX1_CTRL);

  // ---------------------------------------------------------------------------
  // Frame compare vector
  // ---------------------------------------------------------------------------
  logic [15:0]         low_bits;
  logic [31:0]         frame_bits;
  logic [31:0]         care_bits;
  logic [NUM_FILT-1:0] hits;

  // Standard frames use data bytes 0 and 1 in place of the low extended bits
  assign low_bits   = mab_ide_i ? mab_eid_i[15:0]
                                : {mab_data_i[7:0], mab_data_i[15:8]};
  assign frame_bits = {mab_sid_i, 3'b000, mab_eid_i[17:16], low_bits};
  // Remote standard frames carry no data, so only the identifier counts
  assign care_bits  = mab_ide_i ? (CARE_SID | CARE_EID_HI | CARE_EID_LO)
                    : (mab_rtr_i ? CARE_SID : (CARE_SID | CARE_EID_LO));

  // ---------------------------------------------------------------------------
  // Per-filter storage and compare
  // ---------------------------------------------------------------------------
  genvar gi;
  generate
    for (gi = 0; gi < NUM_FILT; gi++) begin : g_filt
      localparam int MIDX = (gi < BUF0_FILTS) ? 0 : 1;

      assign filt_sel[gi] = (reg_idx[IDX_W-1:2] == FILT_BASE[gi][IDX_W-1:2]);

      // Filter words change only in configuration mode
      always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
          filt[gi] <= FILT_RESET;
        end else if (wr_take && config_mode && filt_sel[gi]) begin
          filt[gi] <= (filt[gi] & ~lane_mask) | (lane_data & lane_mask & FILT_IMPL);
        end
      end

      // Filters 0,1 share mask 0; filters 2..5 share mask 1
      acceptance_match u_match (
        .filter_i     (filt[gi]),
        .mask_i       (mask[MIDX]),
        .frame_bits_i (frame_bits),
        .care_i       (care_bits),
        .ide_i        (mab_ide_i),
        .hit_o        (hits[gi])
      );
    end

    for (gi = 0; gi < NUM_MASK; gi++) begin : g_mask
      assign mask_sel[gi] = (reg_idx[IDX_W-1:2] == MASK_BASE[gi][IDX_W-1:2]);

      // Mask words change only in configuration mode
      always_ff @(posedge sys_clk_i or negedge rstn_i) begin
        if (!rstn_i) begin
          mask[gi] <= MASK_RESET;
        end else if (wr_take && config_mode && mask_sel[gi]) begin
          mask[gi] <= (mask[gi] & ~lane_mask) | (lane_data & lane_mask & MASK_IMPL);
        end
      end
    end
  endgenerate

  // ---------------------------------------------------------------------------
  // Acceptance decision
  // ---------------------------------------------------------------------------
  // Lowest-numbered hit among the buffer 1 filters
  function automatic logic [FILTER_HIT_CODE_W-1:0] first_hit(input logic [NUM_FILT-1:0] h);
    logic [FILTER_HIT_CODE_W-1:0] code;
    code = '0;
    for (int i = NUM_FILT - 1; i >= BUF0_FILTS; i--) begin
      if (h[i]) begin
        code = FILTER_HIT_CODE_W'(i);
      end
    end
    return code;
  endfunction : first_hit

  logic                frame_ok;
  logic                hit0;
  logic                hit1;
  logic                code0;
  logic                roll;
  logic                store0;
  logic                store1;
  logic [FILTER_HIT_CODE_W-1:0] code1;

  // Frames are ignored while the filters are being reconfigured
  assign frame_ok = mab_valid_i && !config_mode;
  assign hit0     = hits[0] || hits[1];
  assign hit1     = |hits[NUM_FILT-1:BUF0_FILTS];
  assign code0    = !hits[0];
  assign roll     = hit0 && rx0_full_i && rollover_enable;
  // Buffer 0 has priority, so a frame lands in one buffer at most
  assign store0   = frame_ok && hit0 && !rx0_full_i;
  assign store1   = frame_ok && !rx1_full_i && (roll || (!hit0 && hit1));
  // Rollover carries the buffer 0 filter number into buffer 1
  assign code1    = hit0 ? {2'b00, code0} : first_hit(hits);

  // ---------------------------------------------------------------------------
  // Frame image for the receive buffers
  // ---------------------------------------------------------------------------
  logic [REG_W-1:0] frame_bytes [0:BUF_BYTES-1];

  assign frame_bytes[0] = mab_sid_i[10:3];
  assign frame_bytes[1] = {mab_sid_i[2:0], 1'b0, mab_ide_i, 1'b0, mab_eid_i[17:16]};
  assign frame_bytes[2] = mab_eid_i[15:8];
  assign frame_bytes[3] = mab_eid_i[7:0];
  assign frame_bytes[4] = {1'b0, mab_rtr_i, 2'b00, mab_dlc_i};

  generate
    for (gi = 0; gi < DATA_BYTES; gi++) begin : g_data
      assign frame_bytes[HDR_BYTES+gi] = mab_data_i[gi*REG_W +: REG_W];
    end
  endgenerate

  // Buffer contents; a dropped frame leaves both buffers as they were
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      for (int b = 0; b < NUM_BUF; b++) begin
        for (int k = 0; k < BUF_BYTES; k++) begin
          buf_mem[b][k] <= BYTE_RESET;
        end
      end
    end else begin
      for (int k = 0; k < BUF_BYTES; k++) begin
        if (store0) begin
          buf_mem[0][k] <= frame_bytes[k];
        end
        if (store1) begin
          buf_mem[1][k] <= frame_bytes[k];
        end
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Control registers
  // ---------------------------------------------------------------------------
  // Filter-hit fields move only when a frame is really stored
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      filter_hit_bit0  <= 1'b0;
      filter_hit_code1 <= '0;
    end else begin
      if (store0 || (store1 && roll)) begin
        filter_hit_bit0 <= code0;
      end
      if (store1) begin
        filter_hit_code1 <= code1;
      end
    end
  end

  // Mode and rollover bits are writable at any time
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      config_mode     <= CONFIG_RESET;
      rollover_enable <= ROLLOVER_ENABLE_RESET;
    end else if (wr_take) begin
      if (mode_sel) begin
        config_mode <= avs_writedata_i[CONFIG_BIT];
      end
      if (ctrl0_sel) begin
        rollover_enable <= avs_writedata_i[ROLLOVER_ENABLE_BIT];
      end
    end
  end

  // ---------------------------------------------------------------------------
  // Read mux
  // ---------------------------------------------------------------------------
  logic [31:0] filt_rd;
  logic [31:0] mask_rd;

  // Unmapped indices read as zero
  always_comb begin
    filt_rd = '0;
    mask_rd = '0;
    for (int i = 0; i < NUM_FILT; i++) begin
      if (filt_sel[i]) begin
        filt_rd = filt[i] >> lane_shift;
      end
    end
    for (int i = 0; i < NUM_MASK; i++) begin
      if (mask_sel[i]) begin
        mask_rd = mask[i] >> lane_shift;
      end
    end
    if (|filt_sel) begin
      rd_byte = filt_rd[REG_W-1:0];
    end else if (|mask_sel) begin
      rd_byte = mask_rd[REG_W-1:0];
    end else if (mode_sel) begin
      rd_byte = {7'h00, config_mode};
    end else if (ctrl0_sel) begin
      // Rollover, its read-only copy, then the hit bit
      rd_byte = {5'h00, rollover_enable, rollover_enable, filter_hit_bit0};
    end else if (ctrl1_sel) begin
      rd_byte = {5'h00, filter_hit_code1};
    end else if (buf0_sel) begin
      rd_byte = buf_mem[0][off0[3:0] - 4'h1];
    end else if (buf1_sel) begin
      rd_byte = buf_mem[1][off1[3:0] - 4'h1];
    end else begin
      rd_byte = BYTE_RESET;
    end
  end

  // ---------------------------------------------------------------------------
  // Bus handshake and output flops
  // ---------------------------------------------------------------------------
  // Read data is caught in the wait cycle so it stands when waitrequest drops
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      waitreq  <= 1'b1;
      readdata <= '0;
    end else begin
      waitreq <= next_waitreq;
      if (rd_take) begin
        readdata <= {24'h00_0000, rd_byte};
      end
    end
  end

  // Store strobes are one-cycle pulses after the decision edge
  always_ff @(posedge sys_clk_i or negedge rstn_i) begin
    if (!rstn_i) begin
      rx0_load <= 1'b0;
      rx1_load <= 1'b0;
    end else begin
      rx0_load <= store0;
      rx1_load <= store1;
    end
  end

  assign avs_readdata_o    = readdata;
  assign avs_waitrequest_o = waitreq;
  assign rx0_load_o        = rx0_load;
  assign rx1_load_o        = rx1_load;
  assign config_mode_o     = config_mode;

endmodule : can_acceptance_filter

// ---- can_accept_pkg.sv ----
package can_accept_pkg;

  // ---------------------------------------------------------------------------
  // Bus and register widths
  // ---------------------------------------------------------------------------
  localparam int          ADDR_W      = 9;
  localparam int          DATA_W      = 32;
  localparam int          REG_W       = 8;
  localparam int          IDX_W       = 7;
  localparam int          WORD_BITS   = 32;

  // ---------------------------------------------------------------------------
  // Filters, masks and receive buffers
  // ---------------------------------------------------------------------------
  localparam int          NUM_FILT    = 6;
  localparam int          NUM_MASK    = 2;
  localparam int          NUM_BUF     = 2;
  localparam int          BUF0_FILTS  = 2;
  localparam int          HDR_BYTES   = 5;
  localparam int          DATA_BYTES  = 8;
  localparam int          BUF_BYTES   = HDR_BYTES + DATA_BYTES;

  // ---------------------------------------------------------------------------
  // Register indices (byte address is four times the index)
  // ---------------------------------------------------------------------------
  localparam logic [IDX_W-1:0] FILT_BASE [0:NUM_FILT-1] =
    '{7'h00, 7'h04, 7'h08, 7'h10, 7'h14, 7'h18};
  localparam logic [IDX_W-1:0] MASK_BASE [0:NUM_MASK-1] = '{7'h20, 7'h24};
  localparam logic [IDX_W-1:0] MODE_CTRL     = 7'h0f;
  localparam logic [IDX_W-1:0] RX0_CTRL      = 7'h60;
  localparam logic [IDX_W-1:0] RX1_CTRL      = 7'h70;
  localparam logic [IDX_W-1:0] RX0_DATA_BYTE = 7'h66;
  localparam logic [IDX_W-1:0] RX1_DATA_BYTE = 7'h76;
  localparam logic [IDX_W-1:0] BUF_SPAN      = 7'h0d;

  // ---------------------------------------------------------------------------
  // Packed filter/mask word: [31:24] sid hi, [23:16] sid lo, [15:0] ext low
  // ---------------------------------------------------------------------------
  localparam logic [31:0] FILT_IMPL   = 32'hffeb_ffff;
  localparam logic [31:0] MASK_IMPL   = 32'hffe3_ffff;
  localparam logic [31:0] CARE_SID    = 32'hffe0_0000;
  localparam logic [31:0] CARE_EID_HI = 32'h0003_0000;
  localparam logic [31:0] CARE_EID_LO = 32'h0000_ffff;
  localparam logic [31:0] LANE_BYTE   = 32'h0000_00ff;
  localparam int          EXTENDED_ONLY_SELECT_BIT   = 19;
  localparam logic [31:0] FILT_RESET  = 32'h0000_0000;
  localparam logic [31:0] MASK_RESET  = 32'h0000_0000;

  // ---------------------------------------------------------------------------
  // Control register fields and reset values
  // ---------------------------------------------------------------------------
  localparam int          CONFIG_BIT    = 0;
  localparam int          ROLLOVER_ENABLE_BIT      = 2;
  localparam int          FILTER_HIT_CODE_W      = 3;
  localparam logic        CONFIG_RESET  = 1'b1;
  localparam logic        ROLLOVER_ENABLE_RESET    = 1'b0;
  localparam logic [7:0]  BYTE_RESET    = 8'h00;

endpackage : can_accept_pkg

// ---- acceptance_match.sv ----
`timescale 1ns/1ps

module acceptance_match
  import can_accept_pkg::*;
(
  // Filter and mask words
  input  wire logic [31:0] filter_i,
  input  wire logic [31:0] mask_i,
  // Frame compare bits
  input  wire logic [31:0] frame_bits_i,
  input  wire logic [31:0] care_i,
  input  wire logic        ide_i,
  // Result
  output logic             hit_o
);

  // ---------------------------------------------------------------------------
  // Bit compare
  // ---------------------------------------------------------------------------
  // A bit rejects only where mask is one and received differs from filter
  logic [31:0] reject_bits;
  logic        type_ok;

  assign reject_bits = (frame_bits_i ^ filter_i) & mask_i & care_i;
  // Frame type must agree with the filter's extended-only select
  assign type_ok     = (filter_i[EXTENDED_ONLY_SELECT_BIT] == ide_i);
  assign hit_o       = type_ok && !(|reject_bits);

endmodule : acceptance_match

// ---- can_acceptance_filter_properties.sv ----
`timescale 1ns/1ps

module can_acceptance_filter_properties
  import can_accept_pkg::*;
(
  // Clock and reset
  input wire logic              sys_clk_i,
  input wire logic              rstn_i,
  // Register bus
  input wire logic              avs_read_i,
  input wire logic              avs_write_i,
  input wire logic [DATA_W-1:0] avs_readdata_o,
  input wire logic              avs_waitrequest_o,
  // Frame stream and store strobes
  input wire logic              mab_valid_i,
  input wire logic              rx0_full_i,
  input wire logic              rx1_full_i,
  input wire logic              rx0_load_o,
  input wire logic              rx1_load_o,
  input wire logic              config_mode_o
);
  // -------------------------------------------------------------------------
  // Bus and frame checks
  // -------------------------------------------------------------------------
  default clocking cb @(posedge sys_clk_i); endclocking
  default disable iff (!rstn_i);

  // A fresh request is answered after exactly one wait cycle
  sequence s_req; (avs_read_i || avs_write_i) && avs_waitrequest_o; endsequence
  sequence s_ack; !avs_waitrequest_o ##1 avs_waitrequest_o; endsequence
  property p_one_wait; s_req |=> s_ack; endproperty
  property p_idle_wait; !(avs_read_i || avs_write_i) |-> avs_waitrequest_o; endproperty
  property p_rd_upper; avs_read_i && !avs_waitrequest_o |-> avs_readdata_o[31:8] == 24'h0;
  endproperty
  // A store strobe always has a frame taken outside configuration behind it
  property p_load_cause;
    rx0_load_o || rx1_load_o |-> $past(mab_valid_i) && !$past(config_mode_o);
  endproperty
  property p_one_buf; !(rx0_load_o && rx1_load_o); endproperty
  property p_full0; rx0_load_o |-> !$past(rx0_full_i); endproperty
  property p_full1; rx1_load_o |-> !$past(rx1_full_i); endproperty
  property p_cfg_refuse; mab_valid_i && config_mode_o |=> !rx0_load_o && !rx1_load_o;
  endproperty
  // Mode moves only by a completed bus write
  property p_cfg_change;
    $changed(config_mode_o) |-> $past(avs_write_i) && !$past(avs_waitrequest_o);
  endproperty

  a_one_wait:   assert property (p_one_wait)   else $error("wait cycle count wrong");
  a_idle_wait:  assert property (p_idle_wait)  else $error("waitrequest low while idle");
  a_rd_upper:   assert property (p_rd_upper)   else $error("read data upper bits set");
  a_load_cause: assert property (p_load_cause) else $error("store without frame");
  a_one_buf:    assert property (p_one_buf)    else $error("frame stored twice");
  a_full0:      assert property (p_full0)      else $error("stored in full buffer 0");
  a_full1:      assert property (p_full1)      else $error("stored in full buffer 1");
  a_cfg_refuse: assert property (p_cfg_refuse) else $error("frame taken in config");
  a_cfg_change: assert property (p_cfg_change) else $error("mode changed by itself");
endmodule : can_acceptance_filter_properties

// ---- mab_source.sv ----
`timescale 1ns/1ps

module mab_source (
  // Clock
  input  wire logic        sys_clk_i,
  // Frame towards the acceptance stage
  output logic             valid_o,
  output logic      [10:0] sid_o,
  output logic      [17:0] eid_o,
  output logic             ide_o,
  output logic             rtr_o,
  output logic      [3:0]  dlc_o,
  output logic      [63:0] data_o
);
  // Idle lines start on a busy pattern, never on a frame
  initial begin
    valid_o = 1'b0;
    sid_o   = 11'h555;
    eid_o   = 18'h2aaaa;
    ide_o   = 1'b1;
    rtr_o   = 1'b1;
    dlc_o   = 4'ha;
    data_o  = {4{16'ha5c3}};
  end

  // One whole frame, held until the next send or idle, driven just after an edge
  task automatic send(input logic [10:0] sid, input logic [17:0] eid, input logic ide,
                      input logic rtr, input logic [63:0] data);
    @(posedge sys_clk_i);
    valid_o <= 1'b1;
    sid_o   <= sid;
    eid_o   <= eid;
    ide_o   <= ide;
    rtr_o   <= rtr;
    dlc_o   <= 4'h8;
    data_o  <= data;
  endtask : send

  // Lines invert after a frame so stale values cannot pass for a match
  task automatic idle;
    @(posedge sys_clk_i);
    valid_o <= 1'b0;
    sid_o   <= ~sid_o;
    eid_o   <= ~eid_o;
    ide_o   <= ~ide_o;
    rtr_o   <= ~rtr_o;
    data_o  <= ~data_o;
  endtask : idle
endmodule : mab_source

// ---- tb_can_acceptance_filter.sv ----
`timescale 1ns/1ps

module tb_can_acceptance_filter;
  import can_accept_pkg::*;
  // -------------------------------------------------------------------------
  // Signals and bookkeeping
  // -------------------------------------------------------------------------
  localparam logic [10:0] SIDS [0:5] = '{11'h100, 11'h101, 11'h200, 11'h300, 11'h300, 11'h500};
  logic              sys_clk_i        = 1'b0;
  logic              rstn_i           = 1'b0;
  logic [ADDR_W-1:0] avs_address_i    = '0;
  logic              avs_read_i       = 1'b0;
  logic              avs_write_i      = 1'b0;
  logic [DATA_W-1:0] avs_writedata_i  = '0;
  logic [3:0]        avs_byteenable_i = 4'hf;
  logic [DATA_W-1:0] avs_readdata_o;
  logic              avs_waitrequest_o;
  logic              mab_valid_i, mab_ide_i, mab_rtr_i;
  logic [10:0]       mab_sid_i;
  logic [17:0]       mab_eid_i;
  logic [3:0]        mab_dlc_i;
  logic [63:0]       mab_data_i;
  logic              rx0_full_i       = 1'b0;
  logic              rx1_full_i       = 1'b0;
  logic              rx0_load_o, rx1_load_o, config_mode_o;
  int                n_errors         = 0;
  int                checks           = 0;
  logic [7:0]        q_read [$];
  logic [1:0]        q_load [$];
  logic [7:0]        lfsr             = 8'h46;
  logic [7:0]        key;
  logic              frame_seen       = 1'b0;

  always #2 sys_clk_i = ~sys_clk_i;

  can_acceptance_filter can_acceptance_filter_i (.sys_clk_i, .rstn_i, .avs_address_i,
    .avs_read_i, .avs_write_i, .avs_writedata_i, .avs_byteenable_i, .avs_readdata_o,
    .avs_waitrequest_o, .mab_valid_i, .mab_sid_i, .mab_eid_i, .mab_ide_i, .mab_rtr_i,
    .mab_dlc_i, .mab_data_i, .rx0_full_i, .rx1_full_i, .rx0_load_o, .rx1_load_o,
    .config_mode_o);
  mab_source mab_source_i (.sys_clk_i, .valid_o(mab_valid_i), .sid_o(mab_sid_i),
    .eid_o(mab_eid_i), .ide_o(mab_ide_i), .rtr_o(mab_rtr_i), .dlc_o(mab_dlc_i),
    .data_o(mab_data_i));

  // -------------------------------------------------------------------------
  // Helpers
  // -------------------------------------------------------------------------
  function automatic logic [7:0] lfsr_next(input logic [7:0] s);
    return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
  endfunction : lfsr_next

  task automatic compare_byte(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected read at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : compare_byte

  task automatic compare_load(input logic [1:0] got, input logic [1:0] exp);
    checks++;
    if (got !== exp) begin
      n_errors++;
      $display("unexpected store at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : compare_load

  // Request held until waitrequest is seen low, released at that edge
  task automatic bus_xfer(input logic wr, input logic [IDX_W-1:0] idx, input logic [7:0] d);
    int n;
    @(posedge sys_clk_i);
    avs_address_i   <= {idx, 2'b00};
    avs_writedata_i <= {24'h0, d};
    avs_write_i     <= wr;
    avs_read_i      <= !wr;
    n = 0;
    do begin
      @(posedge sys_clk_i);
      n++;
    end while (avs_waitrequest_o !== 1'b0 && n < 50);
    if (n >= 50) n_errors++;
    avs_write_i <= 1'b0;
    avs_read_i  <= 1'b0;
  endtask : bus_xfer

  task automatic bus_rd(input logic [IDX_W-1:0] idx, input logic [7:0] exp);
    q_read.push_back(exp);
    bus_xfer(1'b0, idx, 8'h00);
  endtask : bus_rd

  // Byte 1 and extended bits 15:0 are random; mask bits there are zero
  task automatic frame(input logic [10:0] sid, input logic ide, input logic rtr,
                       input logic [7:0] b0, input logic [1:0] exp);
    lfsr = lfsr_next(lfsr);
    q_load.push_back(exp);
    mab_source_i.send(sid, {2'b01, lfsr, lfsr}, ide, rtr, {48'h0, lfsr, b0});
  endtask : frame

  // Results are taken off the queues as soon as they appear
  always @(posedge sys_clk_i) begin
    if (avs_read_i && avs_waitrequest_o === 1'b0) begin
      compare_byte(avs_readdata_o[7:0], q_read.pop_front());
    end
    if (frame_seen) begin
      compare_load({rx1_load_o, rx0_load_o}, q_load.pop_front());
    end
    frame_seen <= (mab_valid_i === 1'b1) && rstn_i;
  end

  task automatic complete_run;
    $display("mismatches %0d comparisons %0d", n_errors, checks);
    if (n_errors == 0 && checks > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : complete_run

  // Watchdog: the sequence needs well under a thousand cycles
  initial begin
    #(20000 * 4);
    n_errors++;
    complete_run();
  end

  // -------------------------------------------------------------------------
  // Main sequence
  // -------------------------------------------------------------------------
  initial begin
    repeat (12) @(posedge sys_clk_i);
    rstn_i <= 1'b1;
    bus_rd(MODE_CTRL, 8'h01);
    // Mode output settles well before this point after reset
    compare_byte({7'h00, config_mode_o}, 8'h01);
    bus_rd(RX0_CTRL, 8'h00);
    bus_rd(RX1_CTRL, 8'h00);
    bus_rd(7'h7f, 8'h00);
    key = lfsr_next(lfsr);
    // Masks: whole standard id; mask 0 also checks data byte 0
    bus_xfer(1'b1, MASK_BASE[0], 8'hff);
    bus_xfer(1'b1, MASK_BASE[0] + 7'h1, 8'he0);
    bus_xfer(1'b1, MASK_BASE[0] + 7'h2, 8'hff);
    bus_xfer(1'b1, MASK_BASE[1], 8'hff);
    bus_xfer(1'b1, MASK_BASE[1] + 7'h1, 8'he0);
    for (int f = 0; f < 6; f++) begin
      bus_xfer(1'b1, FILT_BASE[f], SIDS[f][10:3]);
      bus_xfer(1'b1, FILT_BASE[f] + 7'h1, {SIDS[f][2:0], 1'b0, f == 5, 3'b000});
      bus_xfer(1'b1, FILT_BASE[f] + 7'h2, key);
    end
    frame(11'h100, 1'b0, 1'b0, key, 2'b00);
    mab_source_i.idle();
    bus_xfer(1'b1, MODE_CTRL, 8'h00);
    bus_xfer(1'b1, FILT_BASE[0], 8'hff);
    bus_rd(FILT_BASE[0], 8'h20);
    // Looked at cycles after the mode write edge, so the new level stands
    compare_byte({7'h00, config_mode_o}, 8'h00);
    // Back-to-back frames: hit, data byte miss, overlapping filters 3 and 4
    frame(11'h100, 1'b0, 1'b0, key, 2'b01);
    frame(11'h100, 1'b0, 1'b0, ~key, 2'b00);
    frame(11'h300, 1'b0, 1'b0, ~key, 2'b10);
    mab_source_i.idle();
    bus_rd(RX0_CTRL, 8'h00);
    bus_rd(RX1_CTRL, 8'h03);
    bus_rd(RX0_DATA_BYTE, key);
    frame(11'h101, 1'b0, 1'b0, key, 2'b01);
    frame(11'h500, 1'b1, 1'b0, ~key, 2'b10);
    frame(11'h500, 1'b0, 1'b0, ~key, 2'b00);
    mab_source_i.idle();
    bus_rd(RX0_CTRL, 8'h01);
    bus_rd(RX1_CTRL, 8'h05);
    frame(11'h200, 1'b0, 1'b1, ~key, 2'b10);
    mab_source_i.idle();
    bus_rd(RX1_CTRL, 8'h02);
    // Rollover of filter 0 and 1 hits while buffer 0 is full
    bus_xfer(1'b1, RX0_CTRL, 8'h04);
    rx0_full_i <= 1'b1;
    frame(11'h100, 1'b0, 1'b0, key, 2'b10);
    mab_source_i.idle();
    bus_rd(RX1_CTRL, 8'h00);
    bus_rd(RX0_CTRL, 8'h06);
    frame(11'h101, 1'b0, 1'b0, key, 2'b10);
    mab_source_i.idle();
    bus_rd(RX1_CTRL, 8'h01);
    bus_rd(RX0_CTRL, 8'h07);
    // Rollover off, both buffers full: nothing stored, codes kept
    bus_xfer(1'b1, RX0_CTRL, 8'h00);
    rx1_full_i <= 1'b1;
    frame(11'h100, 1'b0, 1'b0, key, 2'b00);
    frame(11'h300, 1'b0, 1'b0, key, 2'b00);
    mab_source_i.idle();
    bus_rd(RX0_CTRL, 8'h01);
    bus_rd(RX1_CTRL, 8'h01);
    repeat (4) @(posedge sys_clk_i);
    complete_run();
  end
endmodule : tb_can_acceptance_filter

bind can_acceptance_filter can_acceptance_filter_properties can_acceptance_filter_properties_i (
  .sys_clk_i, .rstn_i, .avs_read_i, .avs_write_i, .avs_readdata_o, .avs_waitrequest_o,
  .mab_valid_i, .rx0_full_i, .rx1_full_i, .rx0_load_o, .rx1_load_o, .config_mode_o);
